// *** lss_defines.svh ***
// constants for the layer-setting configuration link: frame ids, command bytes,
// reset values, register offsets and timing figures; definitions only
`ifndef LSS_DEFINES_SVH
`define LSS_DEFINES_SVH

// ============================================================
// frame identifiers and command bytes
`define LSS_REQ_ID 11'h7e5
`define LSS_RSP_ID 11'h7e4
`define LSS_RSP_LEN 4'h3
`define LSS_CS_SWITCH 8'h04
`define LSS_CS_NODE 8'h11
`define LSS_CS_RATE 8'h13
`define LSS_CS_ACTIVATE 8'h15
`define LSS_CS_STORE 8'h17
`define LSS_MODE_WAITING 8'h00
`define LSS_MODE_CONFIG 8'h01
`define LSS_RATE_TABLE 8'h00
`define LSS_ERR_NONE 8'h00
`define LSS_ERR_RANGE 8'h01

// ============================================================
// node id and bit-rate index values
`define LSS_NODE_DEFAULT 8'h7f
`define LSS_NODE_MIN 8'h01
`define LSS_NODE_MAX 8'h7f
`define LSS_NODE_KEEP 8'hff
`define LSS_RATE_DEFAULT 4'h4
`define LSS_RATE_1M 4'h0
`define LSS_RATE_800K 4'h1
`define LSS_RATE_500K 4'h2
`define LSS_RATE_250K 4'h3
`define LSS_RATE_125K 4'h4
`define LSS_RATE_RESERVED 4'h5
`define LSS_RATE_50K 4'h6
`define LSS_RATE_20K 4'h7
`define LSS_RATE_10K 4'h8

// ============================================================
// timing: 1 ms timebase on a 20 ns clock
`define LSS_TICK_NS 1000000
`define LSS_CLK_NS 20
`define LSS_TICK_CYCLES ((`LSS_TICK_NS + `LSS_CLK_NS - 1) / `LSS_CLK_NS)

// ============================================================
// controller register map (byte offsets) and fields
`define LSS_REG_CMD 8'h00
`define LSS_REG_STATUS 8'h04
`define LSS_REG_REPLY 8'h08
`define LSS_REG_RATE 8'h0c
`define LSS_OP_CONFIG 3'h0
`define LSS_OP_WAITING 3'h1
`define LSS_OP_NODE 3'h2
`define LSS_OP_RATE 3'h3
`define LSS_OP_ACTIVATE 3'h4
`define LSS_OP_STORE 3'h5

`endif

// *** lss_link.sv ***
// configuration link between the network master and the node
// frames carry id, length and up to three data bytes, byte 0 in bits 7:0;
// each side also shows the bit rate it is sending at
`timescale 1ns/100ps
interface lss_link;
    logic reqValid;
    logic reqReady;
    logic [10:0] reqId;
    logic [3:0] reqLen;
    logic [23:0] reqData;
    logic [3:0] mstRate;
    logic rspValid;
    logic rspReady;
    logic [10:0] rspId;
    logic [3:0] rspLen;
    logic [23:0] rspData;
    logic [3:0] devRate;

    modport dev (
        input reqValid, reqId, reqLen, reqData, mstRate, rspReady,
        output reqReady, rspValid, rspId, rspLen, rspData, devRate
    );
    modport mst (
        output reqValid, reqId, reqLen, reqData, mstRate, rspReady,
        input reqReady, rspValid, rspId, rspLen, rspData, devRate
    );
endinterface

// *** lss_master_ctrl.sv ***
// master end of the configuration link, ordered by software over APB
// one command at a time; a command written while busy is dropped
`timescale 1ns/100ps
`include "lss_defines.svh"
module lss_master_ctrl
    import lss_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lss_link.mst link
);

    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("ADDR_W must be at least eight");
        end
    endgenerate

    // ============================================================
    // state and decode
    mst_state_s s;
    mst_state_s n;
    logic [7:0] addr;
    logic mapped;
    logic [31:0] rdata;
    logic busy;

    assign addr = paddr[7:0];
    assign busy = (s.st != MST_IDLE);
    assign mapped = (addr == `LSS_REG_CMD) || (addr == `LSS_REG_STATUS)
        || (addr == `LSS_REG_REPLY) || (addr == `LSS_REG_RATE);

    always_comb begin
        case (addr)
            `LSS_REG_STATUS: rdata = {24'h0, s.rate, 1'b0, s.fail, s.done, busy};
            `LSS_REG_REPLY: rdata = {8'h00, s.reply};
            `LSS_REG_RATE: rdata = {28'h0, s.rate};
            default: rdata = 32'h0;
        endcase
    end

    // ============================================================
    // next state
    always_comb begin
        n = s;
        n.rspReady = 1'b1;
        if (psel && !penable) begin
            n.pready = 1'b1;
            n.pslverr = !mapped;
            n.prdata = rdata;
        end
        if (psel && penable && s.pready) begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
            if (pwrite && (addr == `LSS_REG_RATE)) begin
                n.rate = pwdata[3:0];
            end
            if (pwrite && (addr == `LSS_REG_CMD) && !busy) begin
                n.done = 1'b0;
                n.fail = 1'b0;
                n.st = MST_SEND;
                n.reqValid = 1'b1;
                n.needReply = 1'b1;
                n.isActivate = 1'b0;
                case (pwdata[2:0])
                    `LSS_OP_CONFIG: begin
                        n.reqLen = 4'h2;
                        n.reqData = {8'h00, `LSS_MODE_CONFIG, `LSS_CS_SWITCH};
                        n.needReply = 1'b0;
                    end
                    `LSS_OP_WAITING: begin
                        n.reqLen = 4'h2;
                        n.reqData = {8'h00, `LSS_MODE_WAITING, `LSS_CS_SWITCH};
                        n.needReply = 1'b0;
                    end
                    `LSS_OP_NODE: begin
                        n.reqLen = 4'h2;
                        n.reqData = {8'h00, pwdata[15:8], `LSS_CS_NODE};
                    end
                    `LSS_OP_RATE: begin
                        n.reqLen = 4'h3;
                        n.reqData = {pwdata[15:8], `LSS_RATE_TABLE, `LSS_CS_RATE};
                    end
                    `LSS_OP_ACTIVATE: begin
                        n.reqLen = 4'h3;
                        n.reqData = {pwdata[23:16], pwdata[15:8], `LSS_CS_ACTIVATE};
                        n.needReply = 1'b0;
                        n.isActivate = 1'b1;
                    end
                    `LSS_OP_STORE: begin
                        n.reqLen = 4'h1;
                        n.reqData = {16'h0000, `LSS_CS_STORE};
                    end
                    default: begin
                        n.st = MST_IDLE;
                        n.reqValid = 1'b0;
                        n.done = 1'b1;
                        n.fail = 1'b1;
                    end
                endcase
            end
        end
        case (s.st)
            MST_IDLE: begin
            end
            MST_SEND: begin
                if (link.reqReady) begin
                    n.reqValid = 1'b0;
                    if (s.needReply) begin
                        n.st = MST_REPLY;
                    end else begin
                        n.st = MST_IDLE;
                        n.done = 1'b1;
                    end
                    if (s.isActivate) begin
                        n.rate = s.pendRate;
                    end
                end
            end
            MST_REPLY: begin
                if (link.rspValid) begin
                    n.reply = link.rspData;
                    n.done = 1'b1;
                    n.st = MST_IDLE;
                    n.fail = (link.rspId != `LSS_RSP_ID) || (link.rspLen != `LSS_RSP_LEN)
                        || (link.rspData != {16'h0000, s.reqData[7:0]});
                    if (!n.fail && (s.reqData[7:0] == `LSS_CS_RATE)) begin
                        n.pendRate = s.reqData[19:16];
                    end
                end
            end
            default: begin
                n.st = MST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
            s.st <= MST_IDLE;
            s.rate <= `LSS_RATE_DEFAULT;
            s.pendRate <= `LSS_RATE_DEFAULT;
        end else begin
            s <= n;
        end
    end

    // ============================================================
    // outputs
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign link.reqValid = s.reqValid;
    assign link.reqId = `LSS_REQ_ID;
    assign link.reqLen = s.reqLen;
    assign link.reqData = s.reqData;
    assign link.mstRate = s.rate;
    assign link.rspReady = s.rspReady;

endmodule

// *** lss_node_config_slave.sv ***
// node end of the layer-setting configuration link
// assumes the master on the other side of lss_link keeps its own ordering;
// a frame is only understood when both ends run at the same bit-rate index
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "lss_defines.svh"

// Overview of operation
// - strap forces operational state after reset
// - master disables transmit objects for stand-alone
// - factory node id 127, rate 125k
// - id and rate change only via frames
// - switch-state 0x04/0x01 enters configuration
// - command 0x11 sets node id in configuration
// - configure/store reply echoes command, then error byte and a zero byte
// - command 0x17 commits pending settings to storage
// - switch-state 0x04/0x00 waits and self-resets
// - command 0x13 records pending bit-rate index
// - rate index table 0..8, 5 reserved
// - command 0x15 carries 16-bit delay, low first
// - wait delay, switch, wait delay before sending
// - master continues at the new bit rate
module lss_node_config_slave
    import lss_pkg::*;
#(
    parameter int TICK_CYCLES = `LSS_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic startInOperational,
    output logic operational,
    output logic configMode,
    output logic [7:0] nodeId,
    output logic [3:0] bitRate,
    output logic nvWrite,
    output logic [7:0] nvNodeId,
    output logic [3:0] nvRate,
    output logic selfReset,
    lss_link.dev link
);

    // ============================================================
    // elaboration check
    generate
        if (TICK_CYCLES < 1) begin : g_bad_tick
            $error("TICK_CYCLES must be at least one");
        end
    endgenerate

    // ============================================================
    // state and decode
    dev_state_s s;
    dev_state_s n;
    logic accept;
    logic tick;
    logic storeNow;
    logic replyNow;
    logic [7:0] replyErr;
    logic [7:0] cs;
    logic [7:0] b1;
    logic [7:0] b2;

    assign cs = link.reqData[7:0];
    assign b1 = link.reqData[15:8];
    assign b2 = link.reqData[23:16];

    // ============================================================
    // next state
    always_comb begin
        n = s;
        n.nvWrite = 1'b0;
        n.selfReset = 1'b0;
        n.reqReady = 1'b1;
        replyNow = 1'b0;
        replyErr = `LSS_ERR_NONE;
        // a frame sent at another rate is noise to this node
        accept = s.reqReady && link.reqValid && (link.reqId == `LSS_REQ_ID)
            && (link.mstRate == s.bitRate);
        tick = (s.msCnt == 32'(TICK_CYCLES - 1));
        storeNow = accept && (cs == `LSS_CS_STORE) && (link.reqLen == 4'h1)
            && ((s.lss == LSS_CONFIG) || (s.lss == LSS_SWITCH_QUIET));

        n.msCnt = tick ? 32'h0 : s.msCnt + 32'h1;

        // strap sampled on the first edge after reset, never inside it
        if (!s.strapDone) begin
            n.strapDone = 1'b1;
            n.operational = startInOperational;
        end

        if (s.rspValid && link.rspReady) begin
            n.rspValid = 1'b0;
        end
        // replies are held back while the rate switch is in progress
        if (s.rspPend && !s.rspValid && (s.lss != LSS_SWITCH_WAIT)
                && (s.lss != LSS_SWITCH_QUIET)) begin
            n.rspValid = 1'b1;
            n.rspPend = 1'b0;
        end

        if (storeNow) begin
            n.nvWrite = 1'b1;
            n.nvNodeId = s.pendNode;
            n.nvRate = s.pendRate;
            replyNow = 1'b1;
        end

        case (s.lss)
            LSS_WAITING: begin
                // only the switch into configuration is heard here
                if (accept && (cs == `LSS_CS_SWITCH) && (link.reqLen == 4'h2)
                        && (b1 == `LSS_MODE_CONFIG)) begin
                    n.lss = LSS_CONFIG;
                end
            end
            LSS_CONFIG: begin
                if (accept) begin
                    case (cs)
                        `LSS_CS_SWITCH: begin
                            if ((link.reqLen == 4'h2) && (b1 == `LSS_MODE_WAITING)) begin
                                n.lss = LSS_WAITING;
                                n.selfReset = 1'b1;
                                n.operational = 1'b0;
                                // new id takes effect on the self reset
                                if (s.pendNode != `LSS_NODE_KEEP) begin
                                    n.nodeId = s.pendNode;
                                end
                            end
                        end
                        `LSS_CS_NODE: begin
                            if (link.reqLen == 4'h2) begin
                                replyNow = 1'b1;
                                if (((b1 >= `LSS_NODE_MIN) && (b1 <= `LSS_NODE_MAX))
                                        || (b1 == `LSS_NODE_KEEP)) begin
                                    n.pendNode = b1;
                                end else begin
                                    replyErr = `LSS_ERR_RANGE;
                                end
                            end
                        end
                        `LSS_CS_RATE: begin
                            if (link.reqLen == 4'h3) begin
                                replyNow = 1'b1;
                                if ((b1 == `LSS_RATE_TABLE) && (b2 <= {4'h0, `LSS_RATE_10K})
                                        && (b2[3:0] != `LSS_RATE_RESERVED)) begin
                                    n.pendRate = b2[3:0];
                                end else begin
                                    replyErr = `LSS_ERR_RANGE;
                                end
                            end
                        end
                        `LSS_CS_ACTIVATE: begin
                            if (link.reqLen == 4'h3) begin
                                n.delay = {b2, b1};
                                n.delayLeft = {b2, b1};
                                n.msCnt = 32'h0;
                                n.lss = LSS_SWITCH_WAIT;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            LSS_SWITCH_WAIT: begin
                if (s.delayLeft == 16'h0) begin
                    n.bitRate = s.pendRate;
                    n.delayLeft = s.delay;
                    n.msCnt = 32'h0;
                    n.lss = LSS_SWITCH_QUIET;
                end else if (tick) begin
                    n.delayLeft = s.delayLeft - 16'h1;
                end
            end
            LSS_SWITCH_QUIET: begin
                if (s.delayLeft == 16'h0) begin
                    n.lss = LSS_CONFIG;
                end else if (tick) begin
                    n.delayLeft = s.delayLeft - 16'h1;
                end
            end
            default: begin
                n.lss = LSS_WAITING;
            end
        endcase

        if (replyNow) begin
            n.rspPend = 1'b1;
            n.rspData = {8'h00, replyErr, cs};
        end
        n.cfgMode = (n.lss != LSS_WAITING);
    end

    // ============================================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s.lss <= LSS_WAITING;
            s.operational <= 1'b0;
            s.strapDone <= 1'b0;
            s.nodeId <= `LSS_NODE_DEFAULT;
            s.bitRate <= `LSS_RATE_DEFAULT;
            s.pendNode <= `LSS_NODE_DEFAULT;
            s.pendRate <= `LSS_RATE_DEFAULT;
            s.delay <= 16'h0;
            s.delayLeft <= 16'h0;
            s.msCnt <= 32'h0;
            s.reqReady <= 1'b0;
            s.rspValid <= 1'b0;
            s.rspPend <= 1'b0;
            s.rspData <= 24'h0;
            s.nvWrite <= 1'b0;
            s.nvNodeId <= `LSS_NODE_DEFAULT;
            s.nvRate <= `LSS_RATE_DEFAULT;
            s.selfReset <= 1'b0;
            s.cfgMode <= 1'b0;
        end else begin
            s <= n;
        end
    end

    // ============================================================
    // outputs
    assign operational = s.operational;
    assign configMode = s.cfgMode;
    assign nodeId = s.nodeId;
    assign bitRate = s.bitRate;
    assign nvWrite = s.nvWrite;
    assign nvNodeId = s.nvNodeId;
    assign nvRate = s.nvRate;
    assign selfReset = s.selfReset;
    assign link.reqReady = s.reqReady;
    assign link.rspValid = s.rspValid;
    assign link.rspId = `LSS_RSP_ID;
    assign link.rspLen = `LSS_RSP_LEN;
    assign link.rspData = s.rspData;
    assign link.devRate = s.bitRate;

endmodule

// *** lss_node_config_slave_assertions.sv ***
// checker of the link between the master and node ends
// assumes instantiation beside lss_link, its signals tied by name
`timescale 1ns/100ps
`include "lss_defines.svh"
module lss_node_config_slave_assertions #(
    parameter int TICK_CYCLES = `LSS_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic [10:0] reqId,
    input wire logic [3:0] reqLen,
    input wire logic [23:0] reqData,
    input wire logic [3:0] mstRate,
    input wire logic rspValid,
    input wire logic rspReady,
    input wire logic [10:0] rspId,
    input wire logic [3:0] rspLen,
    input wire logic [23:0] rspData,
    input wire logic [3:0] devRate
);
    // ==========
    // shadow of the node state, rebuilt from the frames seen on the link
    typedef struct packed {
        logic cfg;
        logic actRun;
        logic [15:0] dly;
        logic [31:0] since;
        logic [7:0] lastCmd;
        logic [3:0] pend;
    } mon_s;
    mon_s mon;
    mon_s next_mon;
    wire taken = reqValid && reqReady;
    // a frame sent at another bit rate never reaches the node
    wire heard = taken && reqId == 11'h7e5 && mstRate == devRate;
    wire cmdOk = heard && mon.cfg && !mon.actRun;
    wire [7:0] arg = reqData[15:8];
    wire nodeOk = (arg >= 8'h01 && arg <= 8'h7f) || arg == 8'hff;
    wire rateOk = arg == 8'h00 && reqData[23:16] <= 8'h08 && reqData[23:16] != 8'h05;

    always_comb begin
        next_mon = mon;
        if (mon.actRun)
            next_mon.since = mon.since + 32'h1;
        if (heard)
            next_mon.lastCmd = reqData[7:0];
        if (heard && reqLen == 4'h2 && reqData[15:0] == 16'h0104)
            next_mon.cfg = 1'b1;
        if (heard && reqLen == 4'h2 && reqData[15:0] == 16'h0004)
            next_mon.cfg = 1'b0;
        if (cmdOk && reqData[7:0] == 8'h13 && rateOk)
            next_mon.pend = reqData[19:16];
        if (cmdOk && reqData[7:0] == 8'h15) begin
            next_mon.actRun = 1'b1;
            next_mon.since = 32'h0;
            next_mon.dly = reqData[23:8];
        end
        if (rspValid && rspReady)
            next_mon.actRun = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (srst)
            mon <= '0;
        else
            mon <= next_mon;
    end

    // ==========
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_rsp_frame;
        rspValid |-> rspId == 11'h7e4 && rspLen == 4'h3 && rspData[23:16] == 8'h00
            && rspData[7:0] == mon.lastCmd;
    endproperty
    a_rsp_frame: assert property (p_rsp_frame) else $error("bad reply frame");
    property p_node;
        cmdOk && reqLen == 4'h2 && reqData[7:0] == 8'h11
            |-> ##2 rspValid && rspData[15:8] == (nodeOk ? 8'h00 : 8'h01);
    endproperty
    a_node: assert property (p_node) else $error("node id reply wrong");
    property p_rate;
        cmdOk && reqLen == 4'h3 && reqData[7:0] == 8'h13
            |-> ##2 rspValid && rspData[15:8] == (rateOk ? 8'h00 : 8'h01);
    endproperty
    a_rate: assert property (p_rate) else $error("rate reply wrong");
    property p_store;
        cmdOk && reqLen == 4'h1 && reqData[7:0] == 8'h17 |-> ##2 rspValid
            && rspData == 24'h000017;
    endproperty
    a_store: assert property (p_store) else $error("store reply wrong");
    property p_silent;
        taken && (!heard || !mon.cfg || reqData[7:0] == 8'h04) |-> ##1 !rspValid [*3];
    endproperty
    a_silent: assert property (p_silent) else $error("unexpected reply");
    property p_hold;
        mon.actRun && mon.since + TICK_CYCLES < mon.dly * TICK_CYCLES |=> $stable(devRate);
    endproperty
    a_hold: assert property (p_hold) else $error("rate switched early");
    property p_switch;
        mon.actRun && mon.since == mon.dly * TICK_CYCLES + 4 |-> devRate == mon.pend;
    endproperty
    a_switch: assert property (p_switch) else $error("rate not switched");
    property p_quiet;
        rspValid && mon.actRun |-> mon.since + TICK_CYCLES >= 2 * mon.dly * TICK_CYCLES;
    endproperty
    a_quiet: assert property (p_quiet) else $error("reply in quiet time");
endmodule

// *** lss_node_config_slave_tb.sv ***
// bench: master and node ends joined by lss_link, software side over APB
// assumes both design ends and the link checker are compiled before it
`timescale 1ns/100ps
module lss_node_config_slave_tb;
    // short tick keeps the timed delays to a few dozen cycles
    localparam int TICK = 8;
    localparam int DLY = 2;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic strap = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, apbErr;
    logic operational, configMode, nvWrite, selfReset;
    logic [7:0] nodeId, nvNodeId;
    logic [3:0] bitRate, nvRate;
    int failures = 0;
    int checksDone = 0;
    int nvSeen = 0;
    int resets = 0;
    lss_link lnk();

    always #10 clk_sys = ~clk_sys;

    lss_node_config_slave #(.TICK_CYCLES(TICK)) lss_node_config_slave_i (
        .clk_sys(clk_sys), .srst(srst), .startInOperational(strap),
        .operational(operational), .configMode(configMode), .nodeId(nodeId),
        .bitRate(bitRate), .nvWrite(nvWrite), .nvNodeId(nvNodeId), .nvRate(nvRate),
        .selfReset(selfReset), .link(lnk.dev));
    lss_master_ctrl lss_master_ctrl_i (
        .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lnk.mst));
    lss_node_config_slave_assertions #(.TICK_CYCLES(TICK)) checker_i (
        .clk_sys(clk_sys), .srst(srst), .reqValid(lnk.reqValid), .reqReady(lnk.reqReady),
        .reqId(lnk.reqId), .reqLen(lnk.reqLen), .reqData(lnk.reqData),
        .mstRate(lnk.mstRate), .rspValid(lnk.rspValid), .rspReady(lnk.rspReady),
        .rspId(lnk.rspId), .rspLen(lnk.rspLen), .rspData(lnk.rspData),
        .devRate(lnk.devRate));

    always @(posedge clk_sys) begin
        if (nvWrite === 1'b1)
            nvSeen <= nvSeen + 1;
        if (selfReset === 1'b1)
            resets <= resets + 1;
    end

    // ==========
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        apbErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // a node, rate or store command whose frame is swallowed leaves the master busy for good
    task automatic cmd(input logic [31:0] v, output logic [31:0] reply);
        logic [31:0] st;
        apb(1'b1, 8'h00, v, st);
        do begin
            apb(1'b0, 8'h04, 32'h0, st);
        end while (st[0] !== 1'b0);
        apb(1'b0, 8'h08, 32'h0, reply);
    endtask

    task automatic do_reset(input logic s);
        srst <= 1'b1;
        strap <= s;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    // ==========
    // scenarios
    task automatic t_defaults();
        logic [31:0] r;
        chk(32'(nodeId), 32'h7f);
        chk(32'(bitRate), 32'h4);
        chk(32'({operational, configMode}), 32'h0);
        apb(1'b0, 8'h0c, 32'h0, r);
        chk(r, 32'h4);
        apb(1'b0, 8'h10, 32'h0, r);
        chk({r[30:0], apbErr}, 32'h1);
        apb(1'b1, 8'h00, 32'h6, r);
        apb(1'b0, 8'h04, 32'h0, r);
        chk(r, 32'h46);
    endtask

    task automatic t_waiting();
        logic [31:0] r;
        apb(1'b1, 8'h00, 32'h0000_2202, r);
        repeat (20) @(posedge clk_sys);
        apb(1'b0, 8'h04, 32'h0, r);
        chk(r, 32'h41);
        chk(32'(nodeId), 32'h7f);
        chk(32'(nvSeen), 32'h0);
        do_reset(1'b0);
    endtask

    task automatic t_node();
        logic [31:0] r;
        cmd(32'h0, r);
        chk(32'(configMode), 32'h1);
        cmd(32'h0000_2202, r);
        chk(r, 32'h11);
        cmd(32'h0000_8002, r);
        chk(r, 32'h111);
        cmd(32'h5, r);
        chk(r, 32'h17);
        chk(32'({nvSeen[3:0], nvNodeId, nvRate}), 32'h1224);
        cmd(32'h1, r);
        chk(32'(resets), 32'h1);
        chk(32'({nodeId, configMode}), 32'h44);
    endtask

    task automatic t_rate();
        logic [31:0] r;
        int n;
        cmd(32'h0, r);
        for (int i = 0; i < 10; i++) begin
            cmd({16'h0, 8'(i), 8'h03}, r);
            chk(r, {16'h0, ((i == 5 || i > 8) ? 8'h01 : 8'h00), 8'h13});
        end
        cmd(32'h0000_0303, r);
        apb(1'b1, 8'h00, {8'h0, 16'(DLY), 8'h04}, r);
        n = 0;
        while (bitRate !== 4'h3 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(n >= DLY * TICK && n <= DLY * TICK + 4), 32'h1);
        cmd(32'h5, r);
        chk(r, 32'h17);
        chk(32'(nvRate), 32'h3);
        apb(1'b0, 8'h0c, 32'h0, r);
        chk(r, 32'h3);
        cmd(32'h1, r);
        chk(32'(bitRate), 32'h3);
    endtask

    task automatic final_report();
        if (failures == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        do_reset(1'b0);
        t_defaults();
        t_waiting();
        t_node();
        t_rate();
        do_reset(1'b1);
        chk(32'({operational, bitRate}), 32'h14);
        final_report();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        final_report();
    end
endmodule

// *** lss_pkg.sv ***
// types shared by both ends of the configuration link
// assumes lss_defines.svh for all numeric constants
package lss_pkg;

    typedef enum logic [1:0] {
        LSS_WAITING,
        LSS_CONFIG,
        LSS_SWITCH_WAIT,
        LSS_SWITCH_QUIET
    } lss_state_e;

    typedef enum logic [1:0] {
        MST_IDLE,
        MST_SEND,
        MST_REPLY
    } mst_state_e;

    typedef struct packed {
        lss_state_e lss;
        logic operational;
        logic strapDone;
        logic [7:0] nodeId;
        logic [3:0] bitRate;
        logic [7:0] pendNode;
        logic [3:0] pendRate;
        logic [15:0] delay;
        logic [15:0] delayLeft;
        logic [31:0] msCnt;
        logic reqReady;
        logic rspValid;
        logic rspPend;
        logic [23:0] rspData;
        logic nvWrite;
        logic [7:0] nvNodeId;
        logic [3:0] nvRate;
        logic selfReset;
        logic cfgMode;
    } dev_state_s;

    typedef struct packed {
        mst_state_e st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic needReply;
        logic isActivate;
        logic done;
        logic fail;
        logic [23:0] reply;
        logic [3:0] rate;
        logic [3:0] pendRate;
        logic reqValid;
        logic [3:0] reqLen;
        logic [23:0] reqData;
        logic rspReady;
    } mst_state_s;

endpackage
